// [rtl/sbst_map.svh]
// Constants of the memory boundary-scan test access logic.
// How it works
// - External test drives outputs, captures input levels.
// - External test enables drivers with preloaded data.
// - Identification captures fixed value at capture-DR.
// - Identification register shifts between TDI and TDO.
// - Identification selected at reset and test-logic-reset.
// - Bypass routes TDI to TDO via one bit.
// - Sample captures inputs, memory CQ, and memory Q while it drives.
// - Sample places boundary register in shift path.
// - Memory and test clocks may run asynchronously.
// - Output-disable sample forces read-data pins high impedance.
// - Output-disable sample shifts through boundary register.
// - Boundary cell 64 always captures low.
// - Cell 109 gates read-data drive under external test.
// - Control bit loads only in update-DR, test/sample.
`ifndef SBST_MAP_SVH
`define SBST_MAP_SVH

`define SBST_IR_W 3
`define SBST_IR_EXTEST 3'h0
`define SBST_IR_IDCODE 3'h1
`define SBST_IR_SAMPLEZ 3'h2
`define SBST_IR_SAMPLE 3'h4
`define SBST_IR_BYPASS 3'h7
`define SBST_IR_CAPTURE 3'h1
`define SBST_IR_RESET `SBST_IR_IDCODE

`define SBST_ID_W 32
`define SBST_BSR_LEN 110
`define SBST_Q_W 36
`define SBST_CQ_W 2
`define SBST_IN_W 71
`define SBST_Q_LSB 0
`define SBST_CQ_LSB 36
`define SBST_IN_LSB 38
`define SBST_CTRL_CELL 109
`define SBST_NC_CELL 64
`define SBST_NC_IN (`SBST_NC_CELL - `SBST_IN_LSB)
`define SBST_SYNC_W 149

`define SBST_CTRL_RESET 1'b0
`define SBST_UPD_RESET 36'h0

`endif

// [rtl/sbst_pkg.sv]
// Types of the memory boundary-scan test access logic.
`include "sbst_map.svh"
package sbst_pkg;

    typedef enum logic [3:0] {
        TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
        TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
        TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } sbst_tap_state_t;

    typedef enum logic [1:0] {
        PAD_MEM, PAD_EXTEST, PAD_HIZ
    } sbst_pad_mode_t;

    typedef struct packed {
        sbst_tap_state_t state;
        logic [`SBST_IR_W-1:0] ir;
        logic [`SBST_IR_W-1:0] ir_sh;
        logic [`SBST_ID_W-1:0] id_sh;
        logic byp;
        logic [`SBST_BSR_LEN-1:0] bsr_sh;
        logic [`SBST_Q_W-1:0] upd_q;
        logic [`SBST_CQ_W-1:0] upd_cq;
        logic upd_ctrl;
        logic dirty;
        logic req;
        sbst_pad_mode_t x_mode;
        logic [`SBST_Q_W-1:0] x_q;
        logic [`SBST_CQ_W-1:0] x_cq;
        logic x_ctrl;
    } sbst_tck_t;

    typedef struct packed {
        logic tdo;
        logic oe;
    } sbst_tdo_t;

    typedef struct packed {
        logic ack;
        sbst_pad_mode_t mode;
        logic ctrl;
        logic [`SBST_Q_W-1:0] uq;
        logic [`SBST_CQ_W-1:0] ucq;
        logic [`SBST_Q_W-1:0] q_out;
        logic q_oe;
        logic [`SBST_CQ_W-1:0] cq_out;
        logic cq_oe;
    } sbst_clk_t;

endpackage

// [rtl/sbst_sync2.sv]
// Two flip-flop synchroniser for a vector of levels.
`timescale 1ns/1ps
module sbst_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sbst_sync_t;

    sbst_sync_t s_reg;
    sbst_sync_t s_next;

    always_comb begin
        s_next.meta = d;
        s_next.q = s_reg.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.q;
endmodule

// [rtl/sbst_tap.sv]
// Boundary-scan test access port with read-data pad control.
`timescale 1ns/1ps
`include "sbst_map.svh"
module sbst_tap #(
    // Identification value; arbitrary, bit 0 set as the scan standard wants.
    parameter logic [`SBST_ID_W-1:0] ID_CODE = 32'h0aa5_5001
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [`SBST_Q_W-1:0] sram_q,
    input wire logic sram_q_oe,
    input wire logic [`SBST_CQ_W-1:0] sram_cq,
    input wire logic [`SBST_Q_W-1:0] pad_q_in,
    input wire logic [`SBST_CQ_W-1:0] pad_cq_in,
    input wire logic [`SBST_IN_W-1:0] mem_in,
    output logic [`SBST_Q_W-1:0] q_out,
    output logic q_oe,
    output logic [`SBST_CQ_W-1:0] cq_out,
    output logic cq_oe
);
    import sbst_pkg::*;

    function automatic sbst_tap_state_t tap_next(input sbst_tap_state_t s, input logic m);
        case (s)
            TAP_TLR: tap_next = m ? TAP_TLR : TAP_RTI;
            TAP_RTI: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tap_next = m ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            default: tap_next = TAP_TLR;
        endcase
    endfunction

    // Instructions that put the boundary register in the scan path.
    function automatic logic sel_bsr(input logic [`SBST_IR_W-1:0] ir);
        sel_bsr = (ir == `SBST_IR_EXTEST) || (ir == `SBST_IR_SAMPLE) ||
                  (ir == `SBST_IR_SAMPLEZ);
    endfunction

    // Instructions under which the update register and control cell load.
    function automatic logic upd_ok(input logic [`SBST_IR_W-1:0] ir);
        upd_ok = (ir == `SBST_IR_EXTEST) || (ir == `SBST_IR_SAMPLE);
    endfunction

    function automatic sbst_pad_mode_t pad_mode(input logic [`SBST_IR_W-1:0] ir);
        case (ir)
            `SBST_IR_EXTEST: pad_mode = PAD_EXTEST;
            `SBST_IR_SAMPLEZ: pad_mode = PAD_HIZ;
            default: pad_mode = PAD_MEM;
        endcase
    endfunction

    sbst_tck_t tk_reg;
    sbst_tck_t tk_next;
    sbst_tdo_t td_reg;
    sbst_tdo_t td_next;
    sbst_clk_t ck_reg;
    sbst_clk_t ck_next;

    logic [`SBST_SYNC_W-1:0] sync_q;
    logic s_ack;
    logic s_sram_oe;
    logic [`SBST_CQ_W-1:0] s_sram_cq;
    logic [`SBST_Q_W-1:0] s_sram_q;
    logic [`SBST_IN_W-1:0] s_mem;
    logic [`SBST_CQ_W-1:0] s_pad_cq;
    logic [`SBST_Q_W-1:0] s_pad_q;
    logic s_req;
    logic [`SBST_BSR_LEN-1:0] cap_vec;

    // Pins and memory-clock signals reach the TCK logic only through two flops.
    sbst_sync2 #(.W(`SBST_SYNC_W)) u_sync_tck (
        .clk(tck),
        .rst_n(rst_n),
        .d({ck_reg.ack, sram_q_oe, sram_cq, sram_q, mem_in, pad_cq_in, pad_q_in}),
        .q(sync_q)
    );
    assign {s_ack, s_sram_oe, s_sram_cq, s_sram_q, s_mem, s_pad_cq, s_pad_q} = sync_q;

    sbst_sync2 #(.W(1)) u_sync_clk (
        .clk(clk),
        .rst_n(rst_n),
        .d(tk_reg.req),
        .q(s_req)
    );

    // Capture image: pads, or under sample the memory's own CQ and, during a read, its Q.
    always_comb begin
        cap_vec = '0;
        if (tk_reg.ir == `SBST_IR_SAMPLE) begin
            cap_vec[`SBST_Q_LSB +: `SBST_Q_W] = s_sram_oe ? s_sram_q : s_pad_q;
            cap_vec[`SBST_CQ_LSB +: `SBST_CQ_W] = s_sram_cq;
        end else begin
            cap_vec[`SBST_Q_LSB +: `SBST_Q_W] = s_pad_q;
            cap_vec[`SBST_CQ_LSB +: `SBST_CQ_W] = s_pad_cq;
        end
        cap_vec[`SBST_IN_LSB +: `SBST_IN_W] = s_mem;
        cap_vec[`SBST_NC_CELL] = 1'b0;
        cap_vec[`SBST_CTRL_CELL] = tk_reg.upd_ctrl;
    end

    always_comb begin
        tk_next = tk_reg;
        tk_next.state = tap_next(tk_reg.state, tms);
        case (tk_reg.state)
            TAP_TLR: begin
                tk_next.ir = `SBST_IR_RESET;
            end
            TAP_CAP_IR: begin
                tk_next.ir_sh = `SBST_IR_CAPTURE;
            end
            TAP_SH_IR: begin
                tk_next.ir_sh = {tdi, tk_reg.ir_sh[`SBST_IR_W-1:1]};
            end
            TAP_UPD_IR: begin
                tk_next.ir = tk_reg.ir_sh;
            end
            TAP_CAP_DR: begin
                if (tk_reg.ir == `SBST_IR_IDCODE) begin
                    tk_next.id_sh = ID_CODE;
                end else if (sel_bsr(tk_reg.ir)) begin
                    tk_next.bsr_sh = cap_vec;
                end else begin
                    tk_next.byp = 1'b0;
                end
            end
            TAP_SH_DR: begin
                if (tk_reg.ir == `SBST_IR_IDCODE) begin
                    tk_next.id_sh = {tdi, tk_reg.id_sh[`SBST_ID_W-1:1]};
                end else if (sel_bsr(tk_reg.ir)) begin
                    tk_next.bsr_sh = {tdi, tk_reg.bsr_sh[`SBST_BSR_LEN-1:1]};
                end else begin
                    tk_next.byp = tdi;
                end
            end
            TAP_UPD_DR: begin
                if (upd_ok(tk_reg.ir)) begin
                    tk_next.upd_q = tk_reg.bsr_sh[`SBST_Q_LSB +: `SBST_Q_W];
                    tk_next.upd_cq = tk_reg.bsr_sh[`SBST_CQ_LSB +: `SBST_CQ_W];
                    tk_next.upd_ctrl = tk_reg.bsr_sh[`SBST_CTRL_CELL];
                end
            end
            default: begin
            end
        endcase
        // Hand the pad settings to the memory clock; a new change re-arms it.
        if (tk_reg.dirty && (s_ack == tk_reg.req)) begin
            tk_next.x_mode = pad_mode(tk_reg.ir);
            tk_next.x_q = tk_reg.upd_q;
            tk_next.x_cq = tk_reg.upd_cq;
            tk_next.x_ctrl = tk_reg.upd_ctrl;
            tk_next.req = ~tk_reg.req;
            tk_next.dirty = 1'b0;
        end
        if ({tk_next.ir, tk_next.upd_q, tk_next.upd_cq, tk_next.upd_ctrl} !=
            {tk_reg.ir, tk_reg.upd_q, tk_reg.upd_cq, tk_reg.upd_ctrl}) begin
            tk_next.dirty = 1'b1;
        end
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tk_reg <= '0;
            tk_reg.state <= TAP_TLR;
            tk_reg.ir <= `SBST_IR_RESET;
            tk_reg.upd_ctrl <= `SBST_CTRL_RESET;
            tk_reg.upd_q <= `SBST_UPD_RESET;
            tk_reg.x_mode <= PAD_MEM;
        end else begin
            tk_reg <= tk_next;
        end
    end

    // TDO moves on the falling edge and drives only in the shift states.
    always_comb begin
        td_next.oe = (tk_reg.state == TAP_SH_DR) || (tk_reg.state == TAP_SH_IR);
        if (tk_reg.state == TAP_SH_IR) begin
            td_next.tdo = tk_reg.ir_sh[0];
        end else if (tk_reg.state != TAP_SH_DR) begin
            td_next.tdo = 1'b0;
        end else if (tk_reg.ir == `SBST_IR_IDCODE) begin
            td_next.tdo = tk_reg.id_sh[0];
        end else if (sel_bsr(tk_reg.ir)) begin
            td_next.tdo = tk_reg.bsr_sh[0];
        end else begin
            td_next.tdo = tk_reg.byp;
        end
    end

    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            td_reg <= '0;
        end else begin
            td_reg <= td_next;
        end
    end

    assign tdo = td_reg.tdo;
    assign tdo_oe = td_reg.oe;

    // Memory-clock side: take the stable handed-over words, then drive the pads.
    always_comb begin
        ck_next = ck_reg;
        if (s_req != ck_reg.ack) begin
            ck_next.ack = s_req;
            ck_next.mode = tk_reg.x_mode;
            ck_next.uq = tk_reg.x_q;
            ck_next.ucq = tk_reg.x_cq;
            ck_next.ctrl = tk_reg.x_ctrl;
        end
        case (ck_reg.mode)
            PAD_EXTEST: begin
                ck_next.q_out = ck_reg.uq;
                ck_next.q_oe = ck_reg.ctrl;
                ck_next.cq_out = ck_reg.ucq;
                ck_next.cq_oe = 1'b1;
            end
            PAD_HIZ: begin
                ck_next.q_out = '0;
                ck_next.q_oe = 1'b0;
                ck_next.cq_out = '0;
                ck_next.cq_oe = 1'b0;
            end
            default: begin
                ck_next.q_out = sram_q;
                ck_next.q_oe = sram_q_oe;
                ck_next.cq_out = sram_cq;
                ck_next.cq_oe = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_reg <= '0;
            ck_reg.mode <= PAD_MEM;
        end else begin
            ck_reg <= ck_next;
        end
    end

    assign q_out = ck_reg.q_out;
    assign q_oe = ck_reg.q_oe;
    assign cq_out = ck_reg.cq_out;
    assign cq_oe = ck_reg.cq_oe;

    property p_tlr_idcode;
        @(posedge tck) disable iff (!rst_n)
        (tk_reg.state == TAP_TLR) |=> (tk_reg.ir == `SBST_IR_IDCODE);
    endproperty
    a_tlr_idcode: assert property (p_tlr_idcode) else $error("IR not IDCODE after TLR");

    property p_tms_reset;
        @(posedge tck) disable iff (!rst_n)
        tms [*5] |=> (tk_reg.state == TAP_TLR);
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("Five TMS ones miss TLR");

    property p_id_capture;
        @(posedge tck) disable iff (!rst_n)
        (tk_reg.state == TAP_CAP_DR && tk_reg.ir == `SBST_IR_IDCODE) |=> (tk_reg.id_sh == ID_CODE);
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("ID not captured");

    property p_id_shift;
        @(posedge tck) disable iff (!rst_n)
        (tk_reg.state == TAP_SH_DR && tk_reg.ir == `SBST_IR_IDCODE) |=>
            (tk_reg.id_sh == {$past(tdi), $past(tk_reg.id_sh[`SBST_ID_W-1:1])});
    endproperty
    a_id_shift: assert property (p_id_shift) else $error("ID register shift wrong");

    property p_bypass;
        @(posedge tck) disable iff (!rst_n)
        (tk_reg.state == TAP_SH_DR && tk_reg.ir == `SBST_IR_BYPASS) |->
            (tdo == tk_reg.byp) ##1 (tk_reg.byp == $past(tdi));
    endproperty
    a_bypass: assert property (p_bypass) else $error("Bypass path wrong");

    property p_bsr_shift;
        @(posedge tck) disable iff (!rst_n)
        (tk_reg.state == TAP_SH_DR && sel_bsr(tk_reg.ir)) |=>
            (tk_reg.bsr_sh[`SBST_BSR_LEN-1] == $past(tdi));
    endproperty
    a_bsr_shift: assert property (p_bsr_shift) else $error("Boundary shift wrong");

    property p_nc_cell;
        @(posedge tck) disable iff (!rst_n)
        (tk_reg.state == TAP_CAP_DR && sel_bsr(tk_reg.ir)) |=> !tk_reg.bsr_sh[`SBST_NC_CELL];
    endproperty
    a_nc_cell: assert property (p_nc_cell) else $error("Cell 64 not low");

    property p_ctrl_load;
        @(posedge tck) disable iff (!rst_n)
        !(tk_reg.state == TAP_UPD_DR && upd_ok(tk_reg.ir)) |=> $stable(tk_reg.upd_ctrl);
    endproperty
    a_ctrl_load: assert property (p_ctrl_load) else $error("Control bit loaded wrongly");

    property p_tdo_oe;
        @(posedge tck) disable iff (!rst_n)
        tdo_oe == (tk_reg.state == TAP_SH_DR || tk_reg.state == TAP_SH_IR);
    endproperty
    a_tdo_oe: assert property (p_tdo_oe) else $error("TDO enable outside shift");

    property p_hiz;
        @(posedge clk) disable iff (!rst_n)
        (ck_reg.mode == PAD_HIZ) |=> (!q_oe && !cq_oe);
    endproperty
    a_hiz: assert property (p_hiz) else $error("Pads driven under SAMPLE-Z");

    property p_extest;
        @(posedge clk) disable iff (!rst_n)
        (ck_reg.mode == PAD_EXTEST) |=>
            (q_oe == $past(ck_reg.ctrl) && q_out == $past(ck_reg.uq) && cq_oe);
    endproperty
    a_extest: assert property (p_extest) else $error("EXTEST pad drive wrong");

    property p_mem;
        @(posedge clk) disable iff (!rst_n)
        (ck_reg.mode == PAD_MEM) |=> (q_out == $past(sram_q) && q_oe == $past(sram_q_oe));
    endproperty
    a_mem: assert property (p_mem) else $error("Memory drive not passed");

    c_id_shift: cover property (@(posedge tck) disable iff (!rst_n)
        tk_reg.state == TAP_SH_DR && tk_reg.ir == `SBST_IR_IDCODE);
    c_sample_cap: cover property (@(posedge tck) disable iff (!rst_n)
        tk_reg.state == TAP_CAP_DR && tk_reg.ir == `SBST_IR_SAMPLE);
    c_extest_drive: cover property (@(posedge clk) disable iff (!rst_n)
        ck_reg.mode == PAD_EXTEST && ck_reg.ctrl);
    c_hiz: cover property (@(posedge clk) disable iff (!rst_n) ck_reg.mode == PAD_HIZ);
endmodule

// [verif/sbst_ctl_model.sv]
// Behavioural board-level scan controller that drives the test port.
`timescale 1ns/1ps
`include "sbst_map.svh"
module sbst_ctl_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One 6 ns test clock; between operations the clock stands low.
    // Outside shift states the data line toggles so a stale level is never mistaken for data.
    task automatic step(input logic m, input logic d, input logic sh, output logic o);
        tms = m;
        tdi = sh ? d : ~tdi;
        #3 tck = 1'b1;
        o = tdo;
        #3 tck = 1'b0;
    endtask

    task automatic walk(input logic [7:0] seq, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            step(seq[i], 1'b0, 1'b0, o);
        end
    endtask

    // Shifts n bits lowest first, then passes through update to run-test/idle.
    task automatic scan(input logic [`SBST_BSR_LEN-1:0] din, input int n,
                        output logic [`SBST_BSR_LEN-1:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], 1'b1, dout[i]);
        end
        walk(8'h01, 2);
    endtask

    // Only four of the five public instruction codes are ever shifted in.
    task automatic shift_ir(input logic [`SBST_IR_W-1:0] code, output logic [2:0] cap);
        logic [`SBST_BSR_LEN-1:0] o;
        walk(8'h03, 4);
        scan({107'h0, code}, 3, o);
        cap = o[2:0];
    endtask

    task automatic shift_dr(input logic [`SBST_BSR_LEN-1:0] din, input int n,
                            output logic [`SBST_BSR_LEN-1:0] dout);
        walk(8'h01, 3);
        scan(din, n, dout);
    endtask

    task automatic tlr();
        walk(8'h1f, 6);
    endtask

    // Keeps the test clock running in run-test/idle so pad hand-over completes.
    task automatic idle(input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            step(1'b0, 1'b0, 1'b0, o);
        end
    endtask
endmodule

// [verif/sram_boundary_scan_tap_test.sv]
// Self-checking bench for the memory boundary-scan test access logic.
`timescale 1ns/1ps
`include "sbst_map.svh"
module sram_boundary_scan_tap_test;
    // Identification value is arbitrary.
    localparam logic [`SBST_ID_W-1:0] ID = 32'h0c3a_6e01;
    localparam int N = `SBST_BSR_LEN;
    localparam logic [N-1:0] PAT = {1'b1, 71'h0, 2'h2, 36'hc_3a5f_0e96};
    localparam logic [N-1:0] PAT2 = {1'b0, 71'h0, 2'h1, 36'h6_1b2c_3d4e};
    localparam logic [N-1:0] PAT3 = {1'b1, 71'h0, 2'h3, 36'h0_f0f0_0f0f};
    logic clk, rst_n, tck, tms, tdi, tdo, tdo_oe, sram_q_oe, q_oe, cq_oe;
    logic [`SBST_Q_W-1:0] sram_q, pad_q_in, q_out;
    logic [`SBST_CQ_W-1:0] sram_cq, pad_cq_in, cq_out;
    logic [`SBST_IN_W-1:0] mem_in;
    logic [N-1:0] got;
    logic [2:0] ir_cap;
    int error_cnt, checked;

    sbst_tap #(.ID_CODE(ID)) dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .sram_q(sram_q), .sram_q_oe(sram_q_oe), .sram_cq(sram_cq),
        .pad_q_in(pad_q_in), .pad_cq_in(pad_cq_in), .mem_in(mem_in), .q_out(q_out),
        .q_oe(q_oe), .cq_out(cq_out), .cq_oe(cq_oe));
    sbst_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    always #25 clk = ~clk;

    function automatic logic [N-1:0] cap(input logic c, input logic [`SBST_Q_W-1:0] q,
                                         input logic [`SBST_CQ_W-1:0] cq);
        logic [`SBST_IN_W-1:0] m;
        m = mem_in;
        m[`SBST_NC_IN] = 1'b0;
        return {c, m, cq, q};
    endfunction

    task automatic chk(input string nm, input logic [N-1:0] e, input logic [N-1:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic pads(input logic [`SBST_Q_W-1:0] q, input logic qe,
                        input logic [`SBST_CQ_W-1:0] cq, input logic ce);
        ctl.idle(64);
        repeat (4) @(posedge clk);
        #1;
        chk("q_out", N'(q), N'(q_out));
        chk("q_oe", N'(qe), N'(q_oe));
        chk("cq_out", N'(cq), N'(cq_out));
        chk("cq_oe", N'(ce), N'(cq_oe));
    endtask

    task automatic drive(input logic [`SBST_Q_W-1:0] q, input logic oe,
                         input logic [`SBST_Q_W-1:0] pq);
        @(posedge clk);
        sram_q <= q;
        sram_q_oe <= oe;
        pad_q_in <= pq;
    endtask

    task automatic s_idcode();
        // The controller starts in test-logic-reset; one low TMS moves it to idle.
        ctl.idle(1);
        chk("tdo_oe_idle", N'(1'b0), N'(tdo_oe));
        ctl.shift_dr('0, 32, got);
        chk("id", N'(ID), got);
    endtask

    task automatic s_bypass();
        ctl.shift_ir(3'h7, ir_cap);
        chk("ir_capture", N'(3'h1), N'(ir_cap));
        ctl.shift_dr(N'(3'h5), 3, got);
        // Bypass captures 0 and delays the input stream by one bit.
        chk("bypass", N'({2'h1, 1'b0}), got);
        pads(sram_q, sram_q_oe, sram_cq, 1'b1);
    endtask

    task automatic s_sample();
        for (int i = 0; i < 2; i++) begin
            drive(36'h9_a5c3_e17b, i == 0, 36'h3_5e0f_1c2d);
            ctl.shift_ir(3'h4, ir_cap);
            ctl.shift_dr(PAT, N, got);
            // The second pass sees the control bit loaded by the first update.
            chk("sample", cap(i == 1, i == 0 ? sram_q : pad_q_in, sram_cq), got);
        end
        pads(sram_q, sram_q_oe, sram_cq, 1'b1);
    endtask

    task automatic s_extest();
        ctl.shift_ir(3'h0, ir_cap);
        pads(PAT[35:0], 1'b1, PAT[37:36], 1'b1);
        ctl.shift_dr(PAT2, N, got);
        chk("extest", cap(1'b1, pad_q_in, pad_cq_in), got);
        pads(PAT2[35:0], 1'b0, PAT2[37:36], 1'b1);
    endtask

    task automatic s_samplez();
        ctl.shift_ir(3'h2, ir_cap);
        pads('0, 1'b0, '0, 1'b0);
        ctl.shift_dr(PAT3, N, got);
        chk("samplez", cap(1'b0, pad_q_in, pad_cq_in), got);
        ctl.shift_ir(3'h0, ir_cap);
        pads(PAT2[35:0], 1'b0, PAT2[37:36], 1'b1);
    endtask

    task automatic s_reset();
        ctl.tlr();
        drive(36'h1_2345_6789, 1'b1, pad_q_in);
        pads(36'h1_2345_6789, 1'b1, sram_cq, 1'b1);
        ctl.shift_dr('0, 32, got);
        chk("id_after_reset", N'(ID), got);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        sram_q = 36'h5_0a0b_0c0d;
        sram_q_oe = 1'b1;
        sram_cq = 2'h1;
        pad_q_in = 36'h3_5e0f_1c2d;
        pad_cq_in = 2'h2;
        mem_in = 71'h4b_c3d2_e1f0_ffff_ffff;
        error_cnt = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        s_idcode();
        s_bypass();
        s_sample();
        s_extest();
        s_samplez();
        s_reset();
        conclude();
    end
endmodule
